//--- swt_consts.svh
// constants, register map and timing counts of the thermometer command front end
`ifndef SWT_CONSTS_SVH
`define SWT_CONSTS_SVH

// clock and timing
`define CLK_MHZ          200
`define CYC_PER_MS       (`CLK_MHZ * 1000)
`define CONV_TIME_MS     750
`define COPY_TIME_MS     10

// selection commands
`define CMD_ROM_READ     8'h33
`define CMD_ROM_MATCH    8'h55
`define CMD_ROM_SEARCH   8'hf0
`define CMD_ROM_ALL      8'hcc
`define CMD_ROM_ALARM    8'hec
// function commands
`define CMD_CONVERT      8'h44
`define CMD_SP_READ      8'hbe
`define CMD_SP_WRITE     8'h4e
`define CMD_SP_COPY      8'h48
`define CMD_RECALL       8'hb8
`define CMD_PWR_QUERY    8'hb4

// scratchpad layout and reset values
`define SP_LAST_BIT      7'd71
`define SP_WR_LAST_BIT   7'd23
`define SP_RSVD5         8'hff
`define SP_RSVD6         8'h00
`define SP_RSVD7         8'h10
`define TEMP_RST         16'h0550
`define NV_TH_RST        8'h7d
`define NV_TL_RST        8'hc9
`define NV_CFG_RST       8'h7f
`define CFG_RES_LSB      5
`define CFG_FIXED        8'h1f
`define CRC_POLY_REFL    8'h8c

// ahb register byte offsets
`define REG_SENSE        8'h00
`define REG_STATUS       8'h04
`define REG_TEMP         8'h08
`define REG_SCRATCH      8'h0c
`define REG_NVSTORE      8'h10
// status bit positions
`define ST_PARASITE      0
`define ST_SELECTED      1
`define ST_CONVERTING    2
`define ST_ALARM         3
`define ST_BUSY          4

`endif

//--- swt_pkg.sv
// types of the thermometer command front end
package swt_pkg;

   typedef enum logic [3:0] {
      SWT_ROM_CMD, SWT_ROM_READ, SWT_ROM_MATCH, SWT_ROM_SEARCH, SWT_FUNC_CMD,
      SWT_BUSY, SWT_SP_READ, SWT_SP_WRITE, SWT_PWR, SWT_DONE
   } swt_state_t;

   typedef struct packed {
      swt_state_t  st;
      logic [7:0]  sh;
      logic [6:0]  cnt;
      logic [1:0]  ph;
      logic        miss;
      logic        selected;
      logic [15:0] temp;
      logic [7:0]  th;
      logic [7:0]  tl;
      logic [7:0]  cfg;
      logic [7:0]  nv_th;
      logic [7:0]  nv_tl;
      logic [7:0]  nv_cfg;
      logic        alarm;
      logic        conv;
      logic [31:0] busy;
      logic [7:0]  crc;
      logic        rd_bit;
      logic        rd_valid;
      logic [15:0] sense;
      logic        pend;
      logic        pwrite;
      logic [7:0]  paddr;
      logic        hreadyout;
      logic        hresp;
      logic [31:0] hrdata;
   } swt_regs_t;

endpackage

//--- swt_crc_step.sv
// one bit step of the reflected 8-bit check sum used on the scratchpad read
`timescale 1ns/10ps
`include "swt_consts.svh"
module swt_crc_step (
   // running sum and next bit
   input  wire logic [7:0] crc_in,
   input  wire logic       bit_in,
   // updated sum
   output logic      [7:0] crc_out
);
   logic fb;

   // lsb-first shift with feedback folded into the reflected polynomial
   assign fb      = crc_in[0] ^ bit_in;
   assign crc_out = {1'b0, crc_in[7:1]} ^ ({8{fb}} & `CRC_POLY_REFL);
endmodule

//--- swt_thermo_cmd.sv
// command interpreter of a single-wire thermometer slave with ahb-lite register access
`timescale 1ns/10ps
`include "swt_consts.svh"
module swt_thermo_cmd #(
   parameter logic [63:0] ROM_ID      = 64'h3c00_0000_0000_01a7, // arbitrary identity value
   parameter int unsigned CONV_CYCLES = `CONV_TIME_MS * `CYC_PER_MS,
   parameter int unsigned COPY_CYCLES = `COPY_TIME_MS * `CYC_PER_MS
) (
   // clock, reset, enable
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // slot-level link from the bit layer
   input  wire logic        bus_reset,
   input  wire logic        wr_slot,
   input  wire logic        wr_bit,
   input  wire logic        rd_slot,
   output logic             rd_bit,
   output logic             rd_valid,
   // supply sense and status
   input  wire logic        external_supply_pin,
   output logic             selected,
   output logic             converting,
   output logic             alarm
);
   import swt_pkg::*;

   swt_regs_t  s;
   swt_regs_t  next_s;
   logic       sp_bit;
   logic [7:0] sp_cur;
   logic [7:0] crc_nx;

   // result truncated to the configured resolution, low bits forced to zero
   function automatic logic [15:0] res_mask(input logic [15:0] t, input logic [7:0] c);
      logic [1:0] r;
      r = c[`CFG_RES_LSB +: 2];
      case (r)
         2'd0:    res_mask = {t[15:3], 3'b000};
         2'd1:    res_mask = {t[15:2], 2'b00};
         2'd2:    res_mask = {t[15:1], 1'b0};
         default: res_mask = t;
      endcase
   endfunction

   // bits 11:4 compared against both signed trigger bytes
   function automatic logic out_of_range(input logic [15:0] t, input logic [7:0] hi,
                                         input logic [7:0] lo);
      out_of_range = ($signed(t[11:4]) > $signed(hi)) || ($signed(t[11:4]) < $signed(lo));
   endfunction

   // conversion time halves per resolution step below 12 bits
   function automatic logic [31:0] conv_len(input logic [7:0] c);
      conv_len = 32'(CONV_CYCLES) >> (2'd3 - c[`CFG_RES_LSB +: 2]);
   endfunction

   // scratchpad byte by index, last byte is the running check sum
   function automatic logic [7:0] sp_byte(input logic [3:0] i, input swt_regs_t r);
      case (i)
         4'd0:    sp_byte = r.temp[7:0];
         4'd1:    sp_byte = r.temp[15:8];
         4'd2:    sp_byte = r.th;
         4'd3:    sp_byte = r.tl;
         4'd4:    sp_byte = r.cfg;
         4'd5:    sp_byte = `SP_RSVD5;
         4'd6:    sp_byte = `SP_RSVD6;
         4'd7:    sp_byte = `SP_RSVD7;
         default: sp_byte = r.crc;
      endcase
   endfunction

   // register read mux, unmapped words read zero
   function automatic logic [31:0] reg_rd(input logic [7:0] a, input swt_regs_t r);
      case (a)
         `REG_SENSE:   reg_rd = {16'h0000, r.sense};
         `REG_STATUS:  reg_rd = {27'h0, (r.busy != 32'h0), r.alarm, r.conv, r.selected,
                                 ~external_supply_pin};
         `REG_TEMP:    reg_rd = {16'h0000, r.temp};
         `REG_SCRATCH: reg_rd = {8'h00, r.cfg, r.tl, r.th};
         `REG_NVSTORE: reg_rd = {8'h00, r.nv_cfg, r.nv_tl, r.nv_th};
         default:      reg_rd = 32'h0;
      endcase
   endfunction

   // bit being served on a scratchpad read, lsb of each byte first
   assign sp_cur = sp_byte(s.cnt[6:3], s);
   assign sp_bit = sp_cur[s.cnt[2:0]];

   swt_crc_step u_crc (
      .crc_in  (s.crc),
      .bit_in  (sp_bit),
      .crc_out (crc_nx)
   );

   // next-state logic for link, timer and bus slave
   always_comb begin
      logic [7:0] sh_in;
      logic [6:0] cnt_inc;
      sh_in   = {wr_bit, s.sh[7:1]};
      cnt_inc = s.cnt + 7'd1;
      next_s  = s;
      next_s.rd_valid = 1'b0;

      // conversion or copy timer; result lands on the last count
      if (s.busy != 32'h0) begin
         next_s.busy = s.busy - 32'h1;
         if (s.busy == 32'h1 && s.conv) begin
            next_s.conv  = 1'b0;
            next_s.temp  = res_mask(s.sense, s.cfg);
            next_s.alarm = out_of_range(res_mask(s.sense, s.cfg), s.th, s.tl);
         end
      end

      if (rd_slot) begin
         next_s.rd_valid = 1'b1;
         next_s.rd_bit   = 1'b1;
      end

      if (bus_reset) begin
         next_s.st       = SWT_ROM_CMD;
         next_s.selected = 1'b0;
         next_s.cnt      = 7'd0;
         next_s.ph       = 2'd0;
         next_s.miss     = 1'b0;
      end else begin
         case (s.st)
            SWT_ROM_CMD: if (wr_slot) begin
               next_s.sh  = sh_in;
               next_s.cnt = cnt_inc;
               if (s.cnt == 7'd7) begin
                  next_s.cnt = 7'd0;
                  case (sh_in)
                     `CMD_ROM_READ:   next_s.st = SWT_ROM_READ;
                     `CMD_ROM_MATCH:  next_s.st = SWT_ROM_MATCH;
                     `CMD_ROM_SEARCH: next_s.st = SWT_ROM_SEARCH;
                     `CMD_ROM_ALARM:  next_s.st = s.alarm ? SWT_ROM_SEARCH : SWT_DONE;
                     `CMD_ROM_ALL: begin
                        next_s.st       = SWT_FUNC_CMD;
                        next_s.selected = 1'b1;
                     end
                     default:         next_s.st = SWT_DONE;
                  endcase
               end
            end
            SWT_ROM_READ: if (rd_slot) begin
               next_s.rd_bit = ROM_ID[s.cnt[5:0]];
               next_s.cnt    = cnt_inc;
               if (s.cnt == 7'd63) begin
                  next_s.st       = SWT_FUNC_CMD;
                  next_s.selected = 1'b1;
                  next_s.cnt      = 7'd0;
               end
            end
            SWT_ROM_MATCH: if (wr_slot) begin
               next_s.miss = s.miss | (wr_bit != ROM_ID[s.cnt[5:0]]);
               next_s.cnt  = cnt_inc;
               if (s.cnt == 7'd63) begin
                  next_s.selected = ~next_s.miss;
                  next_s.st       = next_s.miss ? SWT_DONE : SWT_FUNC_CMD;
                  next_s.cnt      = 7'd0;
               end
            end
            SWT_ROM_SEARCH: begin
               // true bit, complement, then master's choice
               if (rd_slot && s.ph == 2'd0) begin
                  next_s.rd_bit = ROM_ID[s.cnt[5:0]];
                  next_s.ph     = 2'd1;
               end else if (rd_slot && s.ph == 2'd1) begin
                  next_s.rd_bit = ~ROM_ID[s.cnt[5:0]];
                  next_s.ph     = 2'd2;
               end else if (wr_slot && s.ph == 2'd2) begin
                  next_s.ph  = 2'd0;
                  next_s.cnt = cnt_inc;
                  if (wr_bit != ROM_ID[s.cnt[5:0]]) begin
                     next_s.st = SWT_DONE;
                  end else if (s.cnt == 7'd63) begin
                     next_s.st       = SWT_FUNC_CMD;
                     next_s.selected = 1'b1;
                     next_s.cnt      = 7'd0;
                  end
               end
            end
            SWT_FUNC_CMD: if (wr_slot) begin
               next_s.sh  = sh_in;
               next_s.cnt = cnt_inc;
               if (s.cnt == 7'd7) begin
                  next_s.cnt = 7'd0;
                  next_s.crc = 8'h00;
                  case (sh_in)
                     `CMD_CONVERT: begin
                        next_s.conv = 1'b1;
                        next_s.busy = conv_len(s.cfg);
                        next_s.st   = SWT_BUSY;
                     end
                     `CMD_SP_READ:   next_s.st = SWT_SP_READ;
                     `CMD_SP_WRITE:  next_s.st = SWT_SP_WRITE;
                     `CMD_SP_COPY: begin
                        next_s.nv_th  = s.th;
                        next_s.nv_tl  = s.tl;
                        next_s.nv_cfg = s.cfg;
                        next_s.busy   = 32'(COPY_CYCLES);
                        next_s.st     = SWT_BUSY;
                     end
                     `CMD_RECALL: begin
                        next_s.th  = s.nv_th;
                        next_s.tl  = s.nv_tl;
                        next_s.cfg = s.nv_cfg;
                        next_s.st  = SWT_BUSY;
                     end
                     `CMD_PWR_QUERY: next_s.st = SWT_PWR;
                     default:        next_s.st = SWT_DONE;
                  endcase
               end
            end
            // read slots see 0 while the timer runs, 1 once finished
            SWT_BUSY: if (rd_slot) begin
               next_s.rd_bit = (s.busy == 32'h0);
            end
            SWT_SP_READ: if (rd_slot) begin
               next_s.rd_bit = sp_bit;
               next_s.cnt    = cnt_inc;
               if (s.cnt[6:3] != 4'd8) begin
                  next_s.crc = crc_nx;
               end
               if (s.cnt == `SP_LAST_BIT) begin
                  next_s.st = SWT_DONE;
               end
            end
            SWT_SP_WRITE: if (wr_slot) begin
               next_s.sh  = sh_in;
               next_s.cnt = cnt_inc;
               if (s.cnt[2:0] == 3'd7) begin
                  case (s.cnt[4:3])
                     2'd0:    next_s.th  = sh_in;
                     2'd1:    next_s.tl  = sh_in;
                     default: next_s.cfg = {1'b0, sh_in[`CFG_RES_LSB +: 2], 5'h00}
                                           | `CFG_FIXED;
                  endcase
               end
               if (s.cnt == `SP_WR_LAST_BIT) begin
                  next_s.st = SWT_DONE;
               end
            end
            SWT_PWR: if (rd_slot) begin
               next_s.rd_bit = external_supply_pin;
            end
            default: ; // done: only a bus reset leaves, read slots see 1
         endcase
      end

      // ahb-lite: one wait state, writes take hwdata in the data phase
      next_s.hreadyout = 1'b1;
      next_s.hresp     = 1'b0;
      if (s.pend) begin
         next_s.pend = 1'b0;
         if (s.pwrite && s.paddr == `REG_SENSE) begin
            next_s.sense = hwdata[15:0];
         end else if (!s.pwrite) begin
            next_s.hrdata = reg_rd(s.paddr, s);
         end
      end else if (hsel && htrans[1] && hready) begin
         next_s.pend      = 1'b1;
         next_s.pwrite    = hwrite;
         next_s.paddr     = haddr[7:0];
         next_s.hreadyout = 1'b0;
      end
   end

   // single state register; a low enable freezes everything
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s           <= '0;
         s.st        <= SWT_ROM_CMD;
         s.temp      <= `TEMP_RST;
         s.th        <= `NV_TH_RST;
         s.tl        <= `NV_TL_RST;
         s.cfg       <= `NV_CFG_RST;
         s.nv_th     <= `NV_TH_RST;
         s.nv_tl     <= `NV_TL_RST;
         s.nv_cfg    <= `NV_CFG_RST;
         s.rd_bit    <= 1'b1;
         s.hreadyout <= 1'b1;
      end else if (ce) begin
         s <= next_s;
      end
   end

   // outputs straight from the state register
   assign hrdata     = s.hrdata;
   assign hreadyout  = s.hreadyout;
   assign hresp      = s.hresp;
   assign rd_bit     = s.rd_bit;
   assign rd_valid   = s.rd_valid;
   assign selected   = s.selected;
   assign converting = s.conv;
   assign alarm      = s.alarm;

   // checks
   property p_func_needs_sel;
      @(posedge hclk) disable iff (!hresetn)
      s.st == SWT_FUNC_CMD |-> s.selected;
   endproperty
   a_func_needs_sel: assert property (p_func_needs_sel) else $error("function stage unselected");

   property p_reset_drops;
      @(posedge hclk) disable iff (!hresetn)
      ce && bus_reset |=> s.st == SWT_ROM_CMD && !s.selected;
   endproperty
   a_reset_drops: assert property (p_reset_drops) else $error("bus reset kept selection");

   property p_pwr_answer;
      @(posedge hclk) disable iff (!hresetn)
      ce && rd_slot && !bus_reset && s.st == SWT_PWR
         |=> rd_valid && rd_bit == $past(external_supply_pin);
   endproperty
   a_pwr_answer: assert property (p_pwr_answer) else $error("power query answer wrong");

   property p_alarm_update;
      @(posedge hclk) disable iff (!hresetn)
      $fell(s.conv) |-> s.alarm == out_of_range(s.temp, s.th, s.tl);
   endproperty
   a_alarm_update: assert property (p_alarm_update) else $error("alarm flag stale");

   property p_temp_result;
      @(posedge hclk) disable iff (!hresetn)
      $fell(s.conv) |-> s.temp == res_mask($past(s.sense), $past(s.cfg));
   endproperty
   a_temp_result: assert property (p_temp_result) else $error("result not stored");

   property p_alarm_search;
      @(posedge hclk) disable iff (!hresetn)
      ce && wr_slot && !bus_reset && s.st == SWT_ROM_CMD && s.cnt == 7'd7
         && {wr_bit, s.sh[7:1]} == `CMD_ROM_ALARM && !s.alarm |=> s.st == SWT_DONE;
   endproperty
   a_alarm_search: assert property (p_alarm_search) else $error("quiet part joined search");

   property p_temp_lsb_first;
      @(posedge hclk) disable iff (!hresetn)
      ce && rd_slot && !bus_reset && s.st == SWT_SP_READ && s.cnt < 7'd16
         |=> rd_bit == $past(s.temp[s.cnt[3:0]]);
   endproperty
   a_temp_lsb_first: assert property (p_temp_lsb_first) else $error("bit order wrong");

   property p_one_function;
      @(posedge hclk) disable iff (!hresetn)
      s.st == SWT_DONE && !(ce && bus_reset) |=> s.st == SWT_DONE;
   endproperty
   a_one_function: assert property (p_one_function) else $error("second command taken");

   property p_conv_bound;
      @(posedge hclk) disable iff (!hresetn)
      s.conv |-> s.busy <= 32'(CONV_CYCLES) && s.busy != 32'h0;
   endproperty
   a_conv_bound: assert property (p_conv_bound) else $error("conversion too long");

   property p_ahb_wait;
      @(posedge hclk) disable iff (!hresetn)
      ce && !s.pend && hsel && htrans[1] && hready |=> !hreadyout;
   endproperty
   a_ahb_wait: assert property (p_ahb_wait) else $error("no wait state");
endmodule

//--- swt_master_model.sv
// single-wire bus master model driving the slot pulses of the bit layer
`timescale 1ns/10ps
module swt_master_model (
   // clock and answers from the device
   input  wire logic hclk,
   input  wire logic rd_bit,
   input  wire logic rd_valid,
   // slot pulses toward the device
   output logic      bus_reset,
   output logic      wr_slot,
   output logic      wr_bit,
   output logic      rd_slot
);
   initial begin
      bus_reset = 1'b0;
      wr_slot   = 1'b0;
      wr_bit    = 1'b0;
      rd_slot   = 1'b0;
   end

   // a transaction always opens with a bus reset
   task automatic link_reset();
      @(posedge hclk) bus_reset <= 1'b1;
      @(posedge hclk) bus_reset <= 1'b0;
   endtask

   // one byte of back-to-back write slots
   task automatic put_byte(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         @(posedge hclk);
         wr_slot <= 1'b1;
         wr_bit  <= b[i];
      end
      @(posedge hclk);
      wr_slot <= 1'b0;
      wr_bit  <= ~b[7]; // no stale level between slots
   endtask

   // read slots; a missing rd_valid shows as unknown so it never matches
   task automatic get_bits(input int n, output logic [71:0] v);
      v = '0;
      for (int i = 0; i < n; i++) begin
         @(posedge hclk);
         rd_slot <= 1'b1;
         @(posedge hclk);
         rd_slot <= 1'b0;
         #1 v[i] = rd_valid ? rd_bit : 1'bx;
      end
   endtask

   // selection then exactly one function code
   task automatic func(input logic [7:0] sel, input logic [7:0] f);
      link_reset();
      put_byte(sel);
      put_byte(f);
   endtask
endmodule

//--- tb.sv
// self-checking bench of the thermometer command front end
`timescale 1ns/10ps
module tb;
   import swt_pkg::*;
   localparam logic [63:0] ID = 64'h5a12_3456_789a_bc3e; // arbitrary value
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic [1:0]  htrans = 2'b00;
   logic        hwrite = 1'b0;
   logic [31:0] haddr = '0;
   logic [31:0] hwdata = '0;
   logic        ce = 1'b1;
   logic        hsel = 1'b1;
   logic [2:0]  hsize = 3'b010;
   logic [31:0] hrdata;
   logic        hreadyout, hresp, rd_bit, rd_valid, selected, converting, alarm;
   logic        bus_reset, wr_slot, wr_bit, rd_slot;
   logic        external_supply_pin = 1'b1;
   logic [15:0] seed = 16'ha84c;
   int          failures = 0;
   int          checks = 0;

   always #2.5 hclk = ~hclk;

   swt_thermo_cmd #(.ROM_ID(ID), .CONV_CYCLES(200), .COPY_CYCLES(50)) uut (
      .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .bus_reset(bus_reset), .wr_slot(wr_slot), .wr_bit(wr_bit), .rd_slot(rd_slot),
      .rd_bit(rd_bit), .rd_valid(rd_valid), .external_supply_pin(external_supply_pin),
      .selected(selected), .converting(converting), .alarm(alarm));

   swt_master_model m (
      .hclk(hclk), .rd_bit(rd_bit), .rd_valid(rd_valid), .bus_reset(bus_reset),
      .wr_slot(wr_slot), .wr_bit(wr_bit), .rd_slot(rd_slot));

   function automatic logic [15:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed;
   endfunction

   // reflected check sum, poly 8c, init 0, lsb first
   function automatic logic [7:0] crc8(logic [63:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 64; i++)
         c = ((c[0] ^ d[i]) ? 8'h8c : 8'h00) ^ (c >> 1);
      return c;
   endfunction

   function automatic logic alm(logic [15:0] t, logic [7:0] h, logic [7:0] l);
      return $signed(t[11:4]) > $signed(h) || $signed(t[11:4]) < $signed(l);
   endfunction

   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // one single ahb-lite transfer; waits on hready, never on a fixed count
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge hclk);
      htrans <= 2'b10;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask

   task automatic stop_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // hang guard, far above the few thousand cycles the tests need
   initial begin
      #100000;
      failures++;
      stop_test();
   end

   initial begin
      logic [71:0] v;
      logic [63:0] sp;
      logic [31:0] r;
      logic [7:0]  th, tl, cfg;
      logic [15:0] s;
      time         t0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      // power-on contents and an unmapped offset
      ahb(1'b0, 8'h08, 32'h0, r);
      chk(r, 32'h0550);
      ahb(1'b0, 8'h10, 32'h0, r);
      chk(r, 32'h7fc97d);
      ahb(1'b0, 8'h14, 32'h0, r);
      chk(r, 32'h0);
      // a transfer without select is ignored, sample stays at reset
      hsel <= 1'b0;
      ahb(1'b1, 8'h00, 32'h0000_1234, r);
      hsel <= 1'b1;
      ahb(1'b0, 8'h00, 32'h0, r);
      chk(r, 32'h0);
      ahb(1'b0, 8'h04, 32'h0, r);
      chk(r[4:0], 5'h00);
      $display("test reset values done");
      // bus reset drops selection; function code as selection is refused
      m.link_reset();
      m.put_byte(8'hcc);
      #1 chk(selected, 1'b1);
      m.link_reset();
      #1 chk(selected, 1'b0);
      m.put_byte(8'hbe);
      m.get_bits(8, v);
      chk(v[7:0], 8'hff);
      chk(converting, 1'b0);
      $display("test selection gate done");
      m.link_reset();
      m.put_byte(8'h33);
      m.get_bits(64, v);
      chk(v[63:0], ID);
      $display("test identity read done");
      // match good and bad identity, then power query on both supplies
      for (int i = 0; i < 4; i++) begin
         external_supply_pin <= i[0];
         m.link_reset();
         m.put_byte(8'h55);
         for (int k = 0; k < 8; k++)
            m.put_byte(ID[8*k+:8] ^ {7'h0, i[1]});
         m.put_byte(8'hb4);
         m.get_bits(2, v);
         chk(v[1:0], i[1] ? 2'b11 : {2{i[0]}});
         ahb(1'b0, 8'h04, 32'h0, r);
         chk(r[0], !i[0]);
      end
      $display("test match and power done");
      // every resolution: load, convert, read back, alarm search
      for (int i = 0; i < 4; i++) begin
         th = (i == 1) ? 8'h80 : (i == 3) ? 8'h7f : rnd();
         tl = (i == 1) ? 8'h7f : (i == 3) ? 8'h80 : rnd();
         s = rnd();
         cfg = {1'b0, i[1:0], 5'h1f};
         m.func(8'hcc, 8'h4e);
         m.put_byte(th);
         m.put_byte(tl);
         m.put_byte(cfg);
         ahb(1'b1, 8'h00, {16'h0, s}, r);
         m.func(8'hcc, 8'h44);
         t0 = $time;
         #1 chk(converting, 1'b1);
         m.get_bits(1, v);
         chk(v[0], 1'b0);
         ahb(1'b0, 8'h04, 32'h0, r);
         chk(r[2], 1'b1);
         while (converting)
            @(posedge hclk);
         chk((($time - t0) / 5) <= (200 >> (3 - i)) + 2, 1'b1);
         ahb(1'b0, 8'h08, 32'h0, r);
         chk(r[15:0], s & (16'hffff << (3 - i)));
         chk(alarm, alm(s & (16'hffff << (3 - i)), th, tl));
         sp = {8'h10, 8'h00, 8'hff, cfg, tl, th, s & (16'hffff << (3 - i))};
         m.func(8'hcc, 8'hbe);
         m.get_bits(72, v);
         chk(v, {crc8(sp), sp});
         m.link_reset();
         m.put_byte(8'hec);
         m.get_bits(2, v);
         chk(v[1:0], alm(s & (16'hffff << (3 - i)), th, tl) ? {~ID[0], ID[0]} : 2'b11);
      end
      $display("test conversions done");
      // copy into the nonvolatile store
      m.func(8'hcc, 8'h48);
      // a low enable freezes the copy timer longer than the copy lasts
      ce <= 1'b0;
      repeat (55) @(posedge hclk);
      ce <= 1'b1;
      m.get_bits(1, v);
      chk(v[0], 1'b0);
      ahb(1'b0, 8'h10, 32'h0, r);
      chk(r, {8'h0, cfg, tl, th});
      repeat (60) @(posedge hclk); // line left idle while the copy runs
      m.get_bits(1, v);
      chk(v[0], 1'b1);
      $display("test copy done");
      // reset in mid-run restores power-on contents and drops selection
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, 8'h10, 32'h0, r);
      chk(r, 32'h7fc97d);
      chk(selected, 1'b0);
      $display("test mid-run reset done");
      stop_test();
   end
endmodule
